//--- hw/regulator_supervisor.sv
// Purpose: supply fault filtering, flags, reset request and bootstrap control
// Assumes: comparators are asynchronous; mode input is on aclk
// Notes:   flags clear by writing one to the status register
`timescale 1ns/1ns
module regulator_supervisor
	import regsup_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire supply_cmp_t       supply_cmp,
	input  wire op_mode_t          op_mode,
	output logic                   prereg_enable_q,
	output logic                   ntc_ref_enable_q,
	output logic                   boot_reload_q,
	output logic                   boot_boost_q,
	output logic                   por_request_q,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	// ---------------------------------------------------------------
	// comparator synchroniser
	// ---------------------------------------------------------------
	logic [CMP_N-1:0] cmp_meta_q;
	supply_cmp_t      cmp_sync_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_meta_q <= '0;
			cmp_sync_q <= '0;
		end else begin
			cmp_meta_q <= supply_cmp;
			cmp_sync_q <= cmp_meta_q;
		end
	end

	// ---------------------------------------------------------------
	// persistence filters
	// ---------------------------------------------------------------
	function automatic logic [FILT_W-1:0] filt_limit(input int idx);
		if (idx == CMP_ANA_UV || idx == CMP_CORE_UV) begin
			return POR_FILT_CNT;
		end
		return FAULT_FILT_CNT;
	endfunction

	logic [CMP_N-1:0] conf;

	genvar gi;
	generate
		for (gi = 0; gi < CMP_N; gi++) begin : g_filt
			logic [FILT_W-1:0] cnt_d;
			logic [FILT_W-1:0] cnt_q;

			always_comb begin
				cnt_d = cnt_q;
				if (!cmp_sync_q[gi]) begin
					cnt_d = '0;
				end else if (cnt_q != filt_limit(gi)) begin
					cnt_d = cnt_q + 1'b1;
				end
			end

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cnt_q <= '0;
				end else begin
					cnt_q <= cnt_d;
				end
			end

			// saturated counter marks a condition that outlasted its filter
			assign conf[gi] = (cnt_q == filt_limit(gi));
		end
	endgenerate

	// ---------------------------------------------------------------
	// latched flags and reset request
	// ---------------------------------------------------------------
	supply_cmp_t   conf_s;
	supply_flags_t set_flags;
	supply_flags_t clr_flags;
	supply_flags_t flags_d;
	supply_flags_t flags_q;
	logic          por_request_d;

	assign conf_s = conf;

	always_comb begin
		set_flags = '0;
		set_flags.prereg_undervolt_flag    = conf_s.pre_uv;
		set_flags.prereg_overvolt_flag     = conf_s.pre_ov;
		set_flags.analog_overvolt_flag     = conf_s.ana_ov;
		set_flags.comm_undervolt_flag      = conf_s.com_uv;
		set_flags.comm_overvolt_flag       = conf_s.com_ov;
		set_flags.reference_undervolt_flag = conf_s.ref_uv;
		set_flags.reference_overvolt_flag  = conf_s.ref_ov;
		set_flags.core_overvolt_flag       = conf_s.core_ov;
		// set wins over a clear in the same cycle
		flags_d = (flags_q & ~clr_flags) | set_flags;
		// analog undervolt gives no flag, only the reset request
		por_request_d = conf_s.ana_uv | conf_s.core_uv;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q       <= '0;
			por_request_q <= 1'b0;
		end else begin
			flags_q       <= flags_d;
			por_request_q <= por_request_d;
		end
	end

	// ---------------------------------------------------------------
	// regulator enables
	// ---------------------------------------------------------------
	logic prereg_enable_d;
	logic ntc_en_d;
	logic ntc_en_q;

	always_comb begin
		prereg_enable_d = 1'b1;
		case (op_mode)
			MODE_SLEEP,
			MODE_SILENT_BAL,
			MODE_CYCLIC_OFF: begin
				prereg_enable_d = 1'b0;
			end
			default: begin
				prereg_enable_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prereg_enable_q  <= 1'b1;
			ntc_ref_enable_q <= CTRL_NTC_EN_RST;
		end else begin
			prereg_enable_q  <= prereg_enable_d;
			ntc_ref_enable_q <= ntc_en_d;
		end
	end

	assign ntc_en_q = ntc_ref_enable_q;

	// ---------------------------------------------------------------
	// bootstrap sequencer
	// ---------------------------------------------------------------
	boot_state_t        boot_d;
	boot_state_t        boot_q;
	logic [PHASE_W-1:0] phase_cnt_d;
	logic [PHASE_W-1:0] phase_cnt_q;
	logic               boot_allowed;

	// overvolt uses the live comparator, not the filtered flag
	assign boot_allowed = (op_mode == MODE_NORMAL)
		&& !flags_q.prereg_undervolt_flag
		&& !cmp_sync_q.pre_ov;

	always_comb begin
		boot_d      = boot_q;
		phase_cnt_d = phase_cnt_q + 1'b1;
		case (boot_q)
			BOOT_OFF: begin
				phase_cnt_d = '0;
				if (boot_allowed) begin
					boot_d = BOOT_RELOAD;
				end
			end
			BOOT_RELOAD: begin
				if (phase_cnt_q == RELOAD_LAST) begin
					boot_d      = BOOT_BOOST;
					phase_cnt_d = '0;
				end
			end
			BOOT_BOOST: begin
				if (phase_cnt_q == BOOST_LAST) begin
					boot_d      = BOOT_RELOAD;
					phase_cnt_d = '0;
				end
			end
			default: begin
				boot_d      = BOOT_OFF;
				phase_cnt_d = '0;
			end
		endcase
		if (!boot_allowed) begin
			boot_d      = BOOT_OFF;
			phase_cnt_d = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_q        <= BOOT_OFF;
			phase_cnt_q   <= '0;
			boot_reload_q <= 1'b0;
			boot_boost_q  <= 1'b0;
		end else begin
			boot_q        <= boot_d;
			phase_cnt_q   <= phase_cnt_d;
			boot_reload_q <= (boot_d == BOOT_RELOAD);
			boot_boost_q  <= (boot_d == BOOT_BOOST);
		end
	end

	// ---------------------------------------------------------------
	// axi4-lite slave
	// ---------------------------------------------------------------
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_STATE);
	endfunction

	logic              aw_hold_d;
	logic              aw_hold_q;
	logic [ADDR_W-1:0] aw_addr_d;
	logic [ADDR_W-1:0] aw_addr_q;
	logic              w_hold_d;
	logic              w_hold_q;
	logic [31:0]       w_data_d;
	logic [31:0]       w_data_q;
	logic              w_strb0_d;
	logic              w_strb0_q;
	logic              awready_d;
	logic              wready_d;
	logic              bvalid_d;
	logic [1:0]        bresp_d;
	logic              arready_d;
	logic              rvalid_d;
	logic [1:0]        rresp_d;
	logic [31:0]       rdata_d;
	logic              do_write;
	logic [31:0]       state_word;

	always_comb begin
		state_word = '0;
		state_word[STATE_BOOT_EN]   = boot_allowed;
		state_word[STATE_RELOAD]    = boot_reload_q;
		state_word[STATE_BOOST]     = boot_boost_q;
		state_word[STATE_PREREG_ON] = prereg_enable_q;
		state_word[STATE_POR_REQ]   = por_request_q;
		state_word[STATE_CONF_LSB +: CMP_N] = conf;
	end

	always_comb begin
		aw_hold_d = aw_hold_q;
		aw_addr_d = aw_addr_q;
		w_hold_d  = w_hold_q;
		w_data_d  = w_data_q;
		w_strb0_d = w_strb0_q;
		bvalid_d  = s_axi_bvalid && !s_axi_bready;
		bresp_d   = s_axi_bresp;
		clr_flags = '0;
		ntc_en_d  = ntc_en_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_d  = 1'b1;
			w_data_d  = s_axi_wdata;
			w_strb0_d = s_axi_wstrb[0];
		end
		do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
		if (do_write) begin
			aw_hold_d = 1'b0;
			w_hold_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
			if (w_strb0_q && aw_addr_q == ADDR_CTRL) begin
				ntc_en_d = w_data_q[CTRL_NTC_EN_BIT];
			end
			if (w_strb0_q && aw_addr_q == ADDR_STATUS) begin
				clr_flags = w_data_q[$bits(supply_flags_t)-1:0];
			end
		end
		awready_d = !aw_hold_d && !bvalid_d;
		wready_d  = !w_hold_d && !bvalid_d;
	end

	always_comb begin
		rvalid_d = s_axi_rvalid && !s_axi_rready;
		rresp_d  = s_axi_rresp;
		rdata_d  = s_axi_rdata;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				ADDR_CTRL: begin
					rdata_d = 32'(ntc_en_q);
				end
				ADDR_STATUS: begin
					rdata_d = 32'(flags_q);
				end
				ADDR_STATE: begin
					rdata_d = state_word;
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q     <= 1'b0;
			aw_addr_q     <= '0;
			w_hold_q      <= 1'b0;
			w_data_q      <= '0;
			w_strb0_q     <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_rdata   <= '0;
		end else begin
			aw_hold_q     <= aw_hold_d;
			aw_addr_q     <= aw_addr_d;
			w_hold_q      <= w_hold_d;
			w_data_q      <= w_data_d;
			w_strb0_q     <= w_strb0_d;
			s_axi_awready <= awready_d;
			s_axi_wready  <= wready_d;
			s_axi_bvalid  <= bvalid_d;
			s_axi_bresp   <= bresp_d;
			s_axi_arready <= arready_d;
			s_axi_rvalid  <= rvalid_d;
			s_axi_rresp   <= rresp_d;
			s_axi_rdata   <= rdata_d;
		end
	end

endmodule

//--- pkg/regsup_pkg.sv
// Purpose: shared constants and types for the regulator supervisor
// Assumes: 100 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   times are kept in their own unit; cycle counts derive from them
package regsup_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int FAULT_FILT_US   = 20;
	// default only, no figure is given for this filter
	localparam int POR_FILT_US     = 20;
	// defaults only, phase lengths are not given
	localparam int RELOAD_PHASE_NS = 1000;
	localparam int BOOST_PHASE_NS  = 1000;

	// least times: round up to whole cycles
	localparam int FAULT_FILT_CYC  = (FAULT_FILT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_FILT_CYC    = (POR_FILT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RELOAD_CYC      = (RELOAD_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BOOST_CYC       = (BOOST_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int FILT_W  = 16;
	localparam int PHASE_W = 12;
	localparam logic [FILT_W-1:0]  FAULT_FILT_CNT = FILT_W'(FAULT_FILT_CYC);
	localparam logic [FILT_W-1:0]  POR_FILT_CNT   = FILT_W'(POR_FILT_CYC);
	localparam logic [PHASE_W-1:0] RELOAD_LAST    = PHASE_W'(RELOAD_CYC - 1);
	localparam logic [PHASE_W-1:0] BOOST_LAST     = PHASE_W'(BOOST_CYC - 1);

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_STATE  = 8'h08;

	localparam int CTRL_NTC_EN_BIT  = 0;
	localparam int STATE_BOOT_EN    = 0;
	localparam int STATE_RELOAD     = 1;
	localparam int STATE_BOOST      = 2;
	localparam int STATE_PREREG_ON  = 3;
	localparam int STATE_POR_REQ    = 4;
	localparam int STATE_CONF_LSB   = 16;

	localparam logic CTRL_NTC_EN_RST = 1'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_INIT,
		MODE_NORMAL,
		MODE_SLEEP,
		MODE_SILENT_BAL,
		MODE_CYCLIC_OFF,
		MODE_CYCLIC_ON
	} op_mode_t;

	typedef enum logic [1:0] {
		BOOT_OFF,
		BOOT_RELOAD,
		BOOT_BOOST
	} boot_state_t;

	localparam int CMP_N       = 10;
	localparam int CMP_ANA_UV  = 2;
	localparam int CMP_CORE_UV = 8;

	// raw comparator outputs, bit order matches the CMP_ indexes
	typedef struct packed {
		logic core_ov;
		logic core_uv;
		logic ref_ov;
		logic ref_uv;
		logic com_ov;
		logic com_uv;
		logic ana_ov;
		logic ana_uv;
		logic pre_ov;
		logic pre_uv;
	} supply_cmp_t;

	typedef struct packed {
		logic core_overvolt_flag;
		logic reference_overvolt_flag;
		logic reference_undervolt_flag;
		logic comm_overvolt_flag;
		logic comm_undervolt_flag;
		logic analog_overvolt_flag;
		logic prereg_overvolt_flag;
		logic prereg_undervolt_flag;
	} supply_flags_t;

endpackage

//--- tb/comparator_bank.sv
// Purpose: model of the supply comparators
// Assumes: level_req comes from the bench
// Notes:   lag of 0..3 cycles mimics slow settling; keep it fixed while a level is high
`timescale 1ns/1ns
module comparator_bank
	import regsup_pkg::*;
(
	input  wire logic        aclk,
	input  wire supply_cmp_t level_req,
	input  wire logic [1:0]  lag,
	output supply_cmp_t      supply_cmp
);
	supply_cmp_t dly_q [4];
	always_ff @(posedge aclk) begin
		dly_q[0] <= level_req;
		for (int k = 1; k < 4; k++) begin
			dly_q[k] <= dly_q[k-1];
		end
	end
	assign supply_cmp = (lag == 2'h0) ? level_req : dly_q[lag - 2'h1];
endmodule

//--- tb/regulator_supervisor_sva.sv
// Purpose: assertions on the supervisor outputs
// Assumes: sees the regulator_supervisor ports only
// Notes:   run-length counters replace long repetitions
`timescale 1ns/1ns
module regulator_supervisor_sva
	import regsup_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire supply_cmp_t supply_cmp,
	input wire op_mode_t    op_mode,
	input wire logic        prereg_enable_q,
	input wire logic        ntc_ref_enable_q,
	input wire logic        boot_reload_q,
	input wire logic        boot_boost_q,
	input wire logic        por_request_q
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ------------------------------
	// run lengths
	// ------------------------------
	logic [15:0] rl_q, bs_q, ana_q, core_q;
	logic [15:0] rl_d, bs_d, ana_d, core_d;
	always_comb begin
		rl_d   = boot_reload_q ? rl_q + 16'h1 : 16'h0;
		bs_d   = boot_boost_q ? bs_q + 16'h1 : 16'h0;
		ana_d  = supply_cmp.ana_uv ? ana_q + 16'h1 : 16'h0;
		core_d = supply_cmp.core_uv ? core_q + 16'h1 : 16'h0;
		if (!aresetn) begin
			{rl_d, bs_d, ana_d, core_d} = '0;
		end
	end
	always_ff @(posedge aclk) begin
		{rl_q, bs_q, ana_q, core_q} <= {rl_d, bs_d, ana_d, core_d};
	end
	// ------------------------------
	// properties
	// ------------------------------
	sequence s_low_power;
		op_mode inside {MODE_SLEEP, MODE_SILENT_BAL, MODE_CYCLIC_OFF};
	endsequence
	sequence s_reload_end;
		$fell(boot_reload_q) ##0 boot_boost_q;
	endsequence
	sequence s_boost_end;
		$fell(boot_boost_q) ##0 boot_reload_q;
	endsequence
	sequence s_boot_idle;
		!boot_reload_q && !boot_boost_q;
	endsequence
	sequence s_uv_long;
		ana_q > 16'd1997 || core_q > 16'd1997;
	endsequence
	AST_PREREG_OFF: assert property (s_low_power |=> !prereg_enable_q)
		else $error("pre-regulator on in low-power mode");
	AST_MODE_GATE: assert property (op_mode != MODE_NORMAL |=> !boot_reload_q && !boot_boost_q)
		else $error("bootstrap active outside normal mode");
	AST_PHASE_EXCL: assert property (!(boot_reload_q && boot_boost_q))
		else $error("both bootstrap phases on");
	AST_BOOST_AFTER: assert property ($rose(boot_boost_q) |-> $past(boot_reload_q))
		else $error("boost without reload before it");
	AST_RELOAD_LEN: assert property (s_reload_end |-> rl_q == 16'(RELOAD_CYC))
		else $error("reload phase length wrong");
	AST_BOOST_LEN: assert property (s_boost_end |-> bs_q == 16'(BOOST_CYC))
		else $error("boost phase length wrong");
	AST_OVERVOLT_STOP: assert property (supply_cmp.pre_ov [*3] |=> s_boot_idle)
		else $error("bootstrap on during overvoltage");
	AST_POR_SET: assert property (ana_q > 16'd2010 || core_q > 16'd2010 |-> por_request_q)
		else $error("reset request missing");
	AST_POR_FILTER: assert property ($rose(por_request_q) |-> s_uv_long)
		else $error("reset request before filter time");
	AST_NTC_RESET: assert property ($rose(aresetn) |-> !ntc_ref_enable_q)
		else $error("reference supply on after reset");
endmodule

bind regulator_supervisor regulator_supervisor_sva regulator_supervisor_sva_i (.aclk, .aresetn,
	.supply_cmp, .op_mode, .prereg_enable_q, .ntc_ref_enable_q, .boot_reload_q, .boot_boost_q,
	.por_request_q);

//--- tb/regulator_supervisor_tb_top.sv
// Purpose: self-checking bench for the regulator supervisor
// Assumes: comparator_bank drives the raw comparator levels
// Notes:   short pulses end just before the filter edge, long ones far past it
`timescale 1ns/1ns
module regulator_supervisor_tb_top;
	import regsup_pkg::*;
	logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic              s_axi_rready, prereg_enable_q, ntc_ref_enable_q, boot_reload_q;
	logic              boot_boost_q, por_request_q;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata, d;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp, r, lag;
	supply_cmp_t       level_req, supply_cmp;
	op_mode_t          op_mode;
	int                err_total = 0, n_checks = 0, seed = 32'h5df8, cyc = 0, exp_status = 0;
	int                smap [10] = '{0, 1, -1, 2, 3, 4, 5, 6, -1, 7};

	regulator_supervisor regulator_supervisor_i (.aclk, .aresetn, .supply_cmp, .op_mode,
		.prereg_enable_q, .ntc_ref_enable_q, .boot_reload_q, .boot_boost_q, .por_request_q,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	comparator_bank comparator_bank_i (.aclk, .level_req, .lag, .supply_cmp);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_total++;
			stop_test();
		end
	end
	// ------------------------------
	// tasks
	// ------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			tick(1);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		tick(1);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			tick(1);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		tick(1);
	endtask
	// level held n cycles; the model sets a flag only for holds far past the filter
	task automatic hold(input int i, input int n);
		lag <= 2'($random(seed));
		tick(1);
		level_req[i] <= 1'b1;
		tick(n);
		chk("por", (i == CMP_ANA_UV || i == CMP_CORE_UV) && n > 2019, por_request_q);
		level_req[i] <= 1'b0;
		tick(10);
		chk("por_end", 0, por_request_q);
		if (n > 2019 && smap[i] >= 0) exp_status |= 1 << smap[i];
	endtask
	task automatic phases();
		int n;
		n = 0;
		while (!boot_reload_q && n < 10) begin
			tick(1);
			n++;
		end
		chk("boot_start", 1, boot_reload_q);
		for (int p = 0; p < 2; p++) begin
			n = 0;
			while (p ? boot_boost_q : boot_reload_q) begin
				tick(1);
				n++;
			end
			chk("phase_len", p ? BOOST_CYC : RELOAD_CYC, n);
			chk("next_phase", 1, p ? boot_reload_q : boot_boost_q);
		end
	endtask
	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, lag} = '0;
		s_axi_wstrb = 4'hf;
		level_req = '0;
		op_mode = MODE_INIT;
		tick(8);
		aresetn <= 1'b1;
		tick(2);
		chk("prereg_rst", 1, prereg_enable_q);
		axr(ADDR_CTRL, d, r);
		chk("ctrl_rst", 0, d);
		repeat (3) begin
			d = $random(seed);
			axw(ADDR_CTRL, d, r);
			chk("ntc_en", d[0], ntc_ref_enable_q);
		end
		// lane 0 disabled: the enable must keep its value
		s_axi_wstrb <= 4'he;
		axw(ADDR_CTRL, ~d, r);
		chk("strb_off", d[0], ntc_ref_enable_q);
		chk("strb_resp", RESP_OKAY, r);
		s_axi_wstrb <= 4'hf;
		axw(8'h0c, 32'h1, r);
		chk("wr_unmapped", RESP_SLVERR, r);
		axr(8'h0c, d, r);
		chk("rd_unmapped", RESP_SLVERR, r);
		chk("rd_unmapped_data", 0, d);
		$display("test registers done");
		for (int m = 0; m < 6; m++) begin
			op_mode <= op_mode_t'(m);
			tick(3);
			chk("prereg", !(m inside {2, 3, 4}), prereg_enable_q);
			if (m != 1) chk("boot_off", 0, {boot_reload_q, boot_boost_q});
		end
		$display("test modes done");
		op_mode <= MODE_INIT;
		for (int i = 0; i < 10; i++) begin
			repeat (2) hold(i, 1990 + ($random(seed) & 32'h7));
			hold(i, 2020);
			axr(ADDR_STATUS, d, r);
			chk("status", exp_status, d & 32'hff);
		end
		axw(ADDR_STATUS, 32'hff, r);
		exp_status = 0;
		axr(ADDR_STATUS, d, r);
		chk("status_clr", exp_status, d & 32'hff);
		// a reset in mid-run must drop the reference supply again
		axw(ADDR_CTRL, 32'h1, r);
		chk("ntc_on", 1, ntc_ref_enable_q);
		aresetn <= 1'b0;
		tick(8);
		aresetn <= 1'b1;
		tick(2);
		chk("ntc_rst", 0, ntc_ref_enable_q);
		chk("prereg_rst2", 1, prereg_enable_q);
		$display("test filters done");
		lag <= 2'h0;
		op_mode <= MODE_NORMAL;
		phases();
		level_req.pre_ov <= 1'b1;
		tick(5);
		chk("ov_stop", 0, {boot_reload_q, boot_boost_q});
		level_req.pre_ov <= 1'b0;
		phases();
		hold(0, 2020);
		tick(300);
		chk("uv_stop", 0, {boot_reload_q, boot_boost_q});
		axw(ADDR_STATUS, 32'h1, r);
		exp_status = 0;
		phases();
		$display("test bootstrap done");
		stop_test();
	end
endmodule
